// ===== common/pwk_bus_if.sv
// pin-level link between controller and host side
`timescale 1ns/10ps
interface pwk_bus_if;
  logic [31:0] adDev;
  logic adDevOe;
  logic [31:0] adHost;
  logic adHostOe;
  logic reqN;
  logic reqOe;
  logic gntN;
  logic intOut;
  logic intOe;
  logic pmeOut;
  logic pmeOe;
  logic rstBus;
  wire [31:0] adLine = adDevOe ? adDev : (adHostOe ? adHost : 32'h0000_0000);
  wire intLineN = !(intOe && !intOut);
  wire pmeLineN = !(pmeOe && !pmeOut);
  wire reqLineN = reqOe ? reqN : 1'b1;
  modport dev (output adDev, adDevOe, reqN, reqOe, intOut, intOe, pmeOut, pmeOe,
    input adLine, gntN, rstBus);
  modport host (output adHost, adHostOe, gntN, rstBus,
    input adLine, reqLineN, intLineN, pmeLineN);
endinterface

// ===== common/pwk_pkg.sv
// types shared by both ends of the host bus port
package pwk_pkg;
  typedef enum logic [1:0] {PWK_IDLE = 2'b00, PWK_REQ = 2'b01, PWK_ADDR = 2'b11, PWK_DATA = 2'b10} pwk_state_t;
  typedef logic [31:0] pwk_word_t;
endpackage

// ===== common/pwk_regs.svh
// constants for the host bus port, interrupt and wake pins
// Notes on behaviour
// - interrupt line low while any event flag set
// - host holds reset at least 100 us
// - all pins released during reset
// - everything sampled and driven on clock rise
// - bus clock 20 to 33 MHz for network; PWK_CLK_MHZ here is 50
// - request asserted when master access needed
// - grant gives ownership, starts master transfer
// - power event pulls wake line low
// - control bit 18 enters wake-on-network mode
// - magic packet in wake mode asserts wake
// - bit 17 selects first or second protocol
// - 32 shared address/data lines, two phases
`ifndef PWK_REGS_SVH
`define PWK_REGS_SVH
`define PWK_CLK_MHZ 50
`define PWK_RESET_US 100
`define PWK_RESET_CYC (`PWK_RESET_US * `PWK_CLK_MHZ)
`define PWK_WAKE_ENABLE_BIT 18
`define PWK_WAKE_PROTO_BIT 17
`define PWK_PULSE_CYC 8'h10
`define PWK_EVT_WIDTH 4
`define PWK_AD_WIDTH 32
`endif

// ===== design/pwk_device.sv
// controller end: master request, interrupt and wake pins
`timescale 1ns/10ps
`include "pwk_regs.svh"
module pwk_device
  import pwk_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  pwk_bus_if.dev bus,
  input wire logic [`PWK_EVT_WIDTH-1:0] eventSet,
  input wire logic [`PWK_EVT_WIDTH-1:0] eventClear,
  input wire logic [31:0] powerControlWrite,
  input wire logic powerControlLoad,
  input wire logic magicPacket,
  input wire logic masterNeed,
  input wire logic [31:0] masterAddr,
  input wire logic [31:0] masterData,
  output logic masterDone,
  output logic [31:0] powerControlRegister,
  output logic [`PWK_EVT_WIDTH-1:0] eventFlags
);
  pwk_state_t state;
  pwk_state_t next_state;
  logic [7:0] pulseCnt;
  logic [7:0] next_pulseCnt;
  logic wakeHold;
  logic next_wakeHold;
  logic [31:0] adOut;
  logic [31:0] next_adOut;
  logic adOe;
  logic next_adOe;
  logic reqActive;
  logic next_reqActive;
  logic next_masterDone;
  logic [31:0] next_powerControl;
  wire [`PWK_EVT_WIDTH-1:0] next_eventFlags;
  wire busReset = rst || bus.rstBus;
  wire wakeEnable = powerControlRegister[`PWK_WAKE_ENABLE_BIT];
  wire wakeProto = powerControlRegister[`PWK_WAKE_PROTO_BIT];
  wire granted = !bus.gntN;
  wire wakeFire = wakeEnable && magicPacket;
  wire wakeClear = bus.rstBus || !wakeEnable;
  wire pulseRunning = pulseCnt != 8'h00;
  wire wakeAsserted = wakeProto ? wakeHold : pulseRunning;
  // bit 17 clear gives a fixed pulse, bit 17 set latches until disabled or bus reset
  wire enterAddr = next_state == PWK_ADDR;
  wire enterData = next_state == PWK_DATA;
  wire enterReq = next_state == PWK_REQ;
  wire inData = state == PWK_DATA;
  assign next_powerControl = powerControlLoad ? powerControlWrite : powerControlRegister;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      powerControlRegister <= 32'h0000_0000;
    end
    else
    begin
      powerControlRegister <= next_powerControl;
    end
  end
  genvar i;
  generate
    for (i = 0; i < `PWK_EVT_WIDTH; i++)
    begin : g_evt
      // set beats clear so a coincident event is not lost
      assign next_eventFlags[i] = bus.rstBus ? 1'b0 : (eventSet[i] ? 1'b1 : (eventClear[i] ? 1'b0 : eventFlags[i]));
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          eventFlags[i] <= 1'b0;
        end
        else
        begin
          eventFlags[i] <= next_eventFlags[i];
        end
      end
    end
  endgenerate
  assign next_wakeHold = wakeClear ? 1'b0 : (wakeHold || wakeFire);
  assign next_pulseCnt = wakeClear ? 8'h00 : (wakeFire ? `PWK_PULSE_CYC : (pulseRunning ? pulseCnt - 8'h01 : pulseCnt));
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wakeHold <= 1'b0;
    end
    else
    begin
      wakeHold <= next_wakeHold;
    end
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pulseCnt <= 8'h00;
    end
    else
    begin
      pulseCnt <= next_pulseCnt;
    end
  end
  always_comb
  begin
    next_state = state;
    case (state)
      PWK_IDLE:
      begin
        if (masterNeed)
        begin
          next_state = PWK_REQ;
        end
      end
      PWK_REQ:
      begin
        if (granted)
        begin
          next_state = PWK_ADDR;
        end
      end
      PWK_ADDR:
      begin
        next_state = PWK_DATA;
      end
      PWK_DATA:
      begin
        if (masterNeed)
        begin
          next_state = PWK_REQ;
        end
        else
        begin
          next_state = PWK_IDLE;
        end
      end
      default:
      begin
        next_state = PWK_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state <= PWK_IDLE;
    end
    else
    begin
      state <= bus.rstBus ? PWK_IDLE : next_state;
    end
  end
  // registered pin drive keeps outputs glitch free
  assign next_adOut = enterAddr ? masterAddr : masterData;
  assign next_adOe = !bus.rstBus && (enterAddr || enterData);
  assign next_reqActive = !bus.rstBus && enterReq;
  assign next_masterDone = !bus.rstBus && inData;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      adOut <= 32'h0000_0000;
    end
    else
    begin
      adOut <= next_adOut;
    end
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      adOe <= 1'b0;
    end
    else
    begin
      adOe <= next_adOe;
    end
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      reqActive <= 1'b0;
    end
    else
    begin
      reqActive <= next_reqActive;
    end
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      masterDone <= 1'b0;
    end
    else
    begin
      masterDone <= next_masterDone;
    end
  end
  assign bus.adDev = adOut;
  assign bus.adDevOe = adOe && !busReset;
  assign bus.reqN = !reqActive;
  assign bus.reqOe = !busReset;
  assign bus.intOut = 1'b0;
  assign bus.intOe = (|eventFlags) && !busReset;
  assign bus.pmeOut = 1'b0;
  assign bus.pmeOe = wakeAsserted && !busReset;
endmodule // pwk_device

// ===== design/pwk_host.sv
// host end: bus reset, arbiter grant and line observation
`timescale 1ns/10ps
`include "pwk_regs.svh"
module pwk_host
  import pwk_pkg::*;
#(
  parameter int RESET_CYC = `PWK_RESET_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst,
  pwk_bus_if.host bus,
  input wire logic resetRequest,
  input wire logic grantEnable,
  output logic intPending,
  output logic wakePending,
  output logic [31:0] capturedWord,
  output logic resetActive
);
  logic [15:0] resetCnt;
  logic gntActive;
  wire reqSeen = !bus.reqLineN;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      resetCnt <= 16'h0000;
    else if (resetRequest)
      resetCnt <= RESET_CYC[15:0];
    else if (resetCnt != 16'h0000)
      resetCnt <= resetCnt - 16'h0001;
  // reset count assumes a 50 MHz clock (PWK_CLK_MHZ), not checked here
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      gntActive <= 1'b0;
      intPending <= 1'b0;
      wakePending <= 1'b0;
      capturedWord <= 32'h0000_0000;
    end
    else
    begin
      gntActive <= grantEnable && reqSeen && (resetCnt == 16'h0000);
      intPending <= !bus.intLineN;
      wakePending <= !bus.pmeLineN;
      capturedWord <= bus.adLine;
    end
  assign resetActive = rst || (resetCnt != 16'h0000);
  assign bus.rstBus = resetActive;
  assign bus.gntN = !gntActive;
  assign bus.adHost = 32'h0000_0000;
  assign bus.adHostOe = 1'b0;
endmodule // pwk_host

// ===== verif/pci_port_interrupt_wake_pins_test.sv
// self-checking bench for both ends of the host bus port
`timescale 1ns/10ps
module pci_port_interrupt_wake_pins_test;
  import pwk_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, resetRequest = 1'b0, grantEnable = 1'b0, magicPacket = 1'b0;
  logic masterNeed = 1'b0, powerControlLoad = 1'b0, masterDone, intPending, wakePending, resetActive;
  logic [3:0] eventSet = 4'h0, eventClear = 4'h0, eventFlags;
  pwk_word_t powerControlWrite = 32'h0, masterAddr = 32'hA5C3_0010, masterData = 32'h5A3C_00FF;
  pwk_word_t powerControlRegister, capturedWord;
  int err_count = 0, comparisons = 0, n, lo;
  pwk_bus_if bus();
  pwk_device pwk_device_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus), .eventSet(eventSet), .eventClear(eventClear),
    .powerControlWrite(powerControlWrite), .powerControlLoad(powerControlLoad), .magicPacket(magicPacket),
    .masterNeed(masterNeed), .masterAddr(masterAddr), .masterData(masterData), .masterDone(masterDone),
    .powerControlRegister(powerControlRegister), .eventFlags(eventFlags));
  // short reset count keeps the run brief
  pwk_host #(.RESET_CYC(20)) pwk_host_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus), .resetRequest(resetRequest),
    .grantEnable(grantEnable), .intPending(intPending), .wakePending(wakePending), .capturedWord(capturedWord),
    .resetActive(resetActive));
  pwk_checker pwk_checker_inst (.clk_sys(clk_sys), .rst(rst), .rstBus(bus.rstBus), .adDevOe(bus.adDevOe),
    .reqOe(bus.reqOe), .gntN(bus.gntN), .intOe(bus.intOe), .intOut(bus.intOut), .pmeOe(bus.pmeOe),
    .pmeOut(bus.pmeOut), .reqLineN(bus.reqLineN));
  initial forever #10 clk_sys = ~clk_sys;
  task chk(input pwk_word_t got, input pwk_word_t exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task tmo;
    if (n >= 60)
    begin
      err_count++;
      report_and_stop;
    end
  endtask
  task t_reset;
    @(posedge clk_sys) resetRequest <= 1'b1;
    @(posedge clk_sys) resetRequest <= 1'b0;
    cyc(2);
    chk({bus.adDevOe, bus.reqOe, bus.intOe, bus.pmeOe, resetActive}, 5'h01);
    for (n = 0; n < 60 && resetActive !== 1'b0; n++) cyc(1);
    tmo;
    chk(n > 15, 1'b1);
  endtask
  task t_master;
    @(posedge clk_sys) masterNeed <= 1'b1;
    cyc(6);
    chk({bus.reqLineN, bus.adDevOe}, 2'h0);
    @(posedge clk_sys) grantEnable <= 1'b1;
    for (n = 0; n < 60 && bus.adDevOe !== 1'b1; n++) cyc(1);
    tmo;
    chk(bus.adLine, masterAddr);
    @(posedge clk_sys) masterNeed <= 1'b0;
    #1;
    chk(bus.adLine, masterData);
    cyc(1);
    chk({masterDone, capturedWord}, {1'b1, masterData});
    cyc(3);
    chk(bus.reqLineN, 1'b1);
  endtask
  task t_int(input logic [3:0] s, input logic [3:0] c, input logic [1:0] exp);
    @(posedge clk_sys)
    begin
      eventSet <= s;
      eventClear <= c;
    end
    @(posedge clk_sys)
    begin
      eventSet <= 4'h0;
      eventClear <= 4'h0;
    end
    cyc(2);
    chk({intPending, bus.intLineN}, exp);
    chk(|eventFlags, exp[1]);
  endtask
  task t_wake(input pwk_word_t ctl, input int expLow);
    @(posedge clk_sys)
    begin
      powerControlWrite <= ctl;
      powerControlLoad <= 1'b1;
    end
    @(posedge clk_sys)
    begin
      powerControlLoad <= 1'b0;
      magicPacket <= 1'b1;
    end
    @(posedge clk_sys) magicPacket <= 1'b0;
    #1;
    lo = 0;
    for (n = 0; n < 40; n++)
    begin
      lo += (bus.pmeLineN === 1'b0);
      cyc(1);
    end
    chk(lo, expLow);
    chk(wakePending, expLow == 40);
    chk(powerControlRegister, ctl);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_master;
    t_int(4'h4, 4'h0, 2'h2);
    t_int(4'h0, 4'h4, 2'h1);
    t_int(4'h2, 4'h2, 2'h2);
    t_int(4'h0, 4'h2, 2'h1);
    t_wake(32'h0, 0);
    t_wake(32'h0004_0000, 16);
    t_wake(32'h0, 0);
    t_wake(32'h0006_0000, 40);
    t_wake(32'h0, 0);
    report_and_stop;
  end
endmodule // pci_port_interrupt_wake_pins_test

// ===== verif/pwk_checker.sv
// assertions on the pins between controller and host end
`timescale 1ns/10ps
module pwk_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rstBus,
  input wire logic adDevOe,
  input wire logic reqOe,
  input wire logic gntN,
  input wire logic intOe,
  input wire logic intOut,
  input wire logic pmeOe,
  input wire logic pmeOut,
  input wire logic reqLineN
);
  default clocking @(posedge clk_sys); endclocking
  // bus reset masks the rest, which may all be mid-transfer
  default disable iff (rst || rstBus);
  sequence sData;
    adDevOe ##1 !adDevOe;
  endsequence
  chk_reset_float: assert property (disable iff (rst) rstBus && $past(rstBus) |-> !(adDevOe | reqOe | intOe | pmeOe))
    else $error("pin driven in bus reset");
  chk_req_held: assert property (!reqLineN && gntN |=> !reqLineN)
    else $error("request dropped before grant");
  chk_grant_tenure: assert property ($fell(gntN) |=> adDevOe ##1 sData)
    else $error("no tenure after grant");
  chk_data_phase: assert property ($rose(adDevOe) |=> sData)
    else $error("bad address or data phase");
  chk_addr_granted: assert property ($rose(adDevOe) |-> !$past(gntN))
    else $error("drive without grant");
  chk_req_idle: assert property ($fell(reqLineN) |-> !adDevOe)
    else $error("request during own tenure");
  chk_int_low: assert property (intOe |-> !intOut)
    else $error("interrupt not pulled low");
  chk_pme_low: assert property (pmeOe |-> !pmeOut)
    else $error("wake not pulled low");
endmodule // pwk_checker
